// [shared/sqa_map.vh]
`ifndef SQA_MAP_VH
`define SQA_MAP_VH

// Register byte offsets
`define SQA_OFF_CMD     8'h00
`define SQA_OFF_DADDR   8'h04
`define SQA_OFF_SW0     8'h08
`define SQA_OFF_SW1     8'h0C
`define SQA_OFF_ACC     8'h10
`define SQA_OFF_PROD    8'h14
`define SQA_OFF_MCAND   8'h18
`define SQA_OFF_STAT    8'h1C
`define SQA_OFF_OPIN    8'h20
`define SQA_OFF_OPOUT   8'h24
`define SQA_OFF_AR_BASE 8'h40
`define SQA_OFF_AR_LAST 8'h5C

// Command word fields
`define SQA_CMD_OP_HI   3
`define SQA_CMD_OP_LO   0
`define SQA_CMD_IND     4
`define SQA_CMD_N_HI    7
`define SQA_CMD_N_LO    5
`define SQA_CMD_NXT_EN  8
`define SQA_CMD_NXT_HI  11
`define SQA_CMD_NXT_LO  9

// Operation codes
`define SQA_OP_SQ_ADD     4'h1
`define SQA_OP_SQ_SUB     4'h2
`define SQA_OP_STORE0     4'h3
`define SQA_OP_STORE_N    4'h4
`define SQA_OP_STORE1     4'h5
`define SQA_OP_SET_SEXT   4'h6
`define SQA_OP_SET_TEST   4'h7
`define SQA_OP_SET_TXMODE 4'h8

// Status word field positions
`define SQA_SW0_PTR_HI  15
`define SQA_SW0_PTR_LO  13
`define SQA_SW1_PSH_HI  1
`define SQA_SW1_PSH_LO  0
`define SQA_SW1_TXMODE  2
`define SQA_SW1_SEXT    10
`define SQA_SW1_TEST    11

// Operand input fields
`define SQA_OPIN_SH_HI  19
`define SQA_OPIN_SH_LO  16

// Reset values
`define SQA_RST_8       8'h00
`define SQA_RST_16      16'h0000
`define SQA_RST_20      20'h0_0000
`define SQA_RST_32      32'h0000_0000

`endif

// [rtl/sqa_shifter.v]
`timescale 1ns/1ps
`include "sqa_map.vh"

module sqa_shifter (
  input  wire [31:0] prod,
  input  wire [1:0]  product_shift_field,
  input  wire [15:0] op_data,
  input  wire [3:0]  op_shift,
  input  wire        sign_ext_mode_bit,
  output reg  [31:0] prod_shifted,
  output wire [31:0] op_shifted
);
  wire [31:0] op_ext;

  // Product scaling ahead of the accumulator
  always @* begin
    case (product_shift_field)
      2'b00:   prod_shifted = prod;                         // RULE_03
      2'b01:   prod_shifted = {prod[30:0], 1'b0};           // RULE_03
      2'b10:   prod_shifted = {prod[27:0], 4'h0};           // RULE_03
      default: prod_shifted = {{6{prod[31]}}, prod[31:6]};  // RULE_03
    endcase
  end

  // Operand widening; low bits always zero fill via the shift
  assign op_ext = {{16{sign_ext_mode_bit & op_data[15]}}, op_data}; // RULE_08
  assign op_shifted = op_ext << op_shift;                          // RULE_08
endmodule

// [rtl/sqa_core.v]
`timescale 1ns/1ps
`include "sqa_map.vh"

// Overview of operation
// RULE_01 - Square-add adds scaled product, loads multiplicand, squares it.
// RULE_02 - Square-sub subtracts scaled product, loads and squares the word.
// RULE_03 - Product shift: none, left one, left four, or signed right six.
// RULE_04 - Plain status store writes status word zero to the memory word.
// RULE_05 - Indexed status store writes the indexed word, direct or indirect.
// RULE_06 - Second status store writes status word one to the memory word.
// RULE_07 - Set-sign-extension forces the sign extension mode bit to one.
// RULE_08 - Sign extension sign-fills high operand bits; low bits zero-fill.
// RULE_09 - The set-test operation forces the test/control flag to one.
// RULE_10 - Set-transmit-mode forces the transmit mode bit, where present.
// RULE_11 - Indirect forms reload the aux pointer after the access if asked.
module sqa_core #(
  parameter HAS_TX_MODE = 1
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  output reg         dmem_req,
  output reg         dmem_we,
  output reg  [15:0] dmem_addr,
  output reg  [15:0] dmem_wdata,
  input  wire [15:0] dmem_rdata
);
  // One-hot states
  localparam [3:0] S_IDLE  = 4'b0001;
  localparam [3:0] S_READ  = 4'b0010;
  localparam [3:0] S_EXEC  = 4'b0100;
  localparam [3:0] S_WRITE = 4'b1000;

  reg  [3:0]  state_reg;
  reg  [15:0] cmd_reg;
  reg  [15:0] daddr_reg;
  reg  [15:0] status_word_zero;
  reg  [15:0] status_word_one;
  reg  [31:0] acc_reg;
  reg  [31:0] prod_reg;
  reg  [15:0] multiplicand_register;
  reg  [19:0] opin_reg;
  reg  [15:0] ar_reg [0:7];
  reg         wr_pend_reg;
  reg  [7:0]  wr_addr_reg;
  reg         go_reg;
  wire [31:0] prod_shifted;
  wire [31:0] op_shifted;
  wire [3:0]  cmd_op;
  wire [2:0]  aux_reg_pointer;
  wire [15:0] eff_addr;
  wire [15:0] sq_op;
  wire [31:0] sq_wide;
  wire        addr_ok;
  integer     i;

  assign hreadyout = 1'b1;   // Zero wait states, so no stall logic needed
  assign hresp     = 1'b0;
  assign addr_ok   = hsel & hready & htrans[1];
  assign cmd_op    = cmd_reg[`SQA_CMD_OP_HI:`SQA_CMD_OP_LO];
  assign aux_reg_pointer =
    status_word_zero[`SQA_SW0_PTR_HI:`SQA_SW0_PTR_LO];
  assign eff_addr  = cmd_reg[`SQA_CMD_IND] ? ar_reg[aux_reg_pointer]
                                           : daddr_reg;
  assign sq_op     = dmem_rdata;
  // Widened with its sign so the 32-bit square stays signed
  assign sq_wide   = {{16{sq_op[15]}}, sq_op};

  sqa_shifter u_shift (
    .prod                (prod_reg),
    .product_shift_field (status_word_one[`SQA_SW1_PSH_HI:`SQA_SW1_PSH_LO]),
    .op_data             (opin_reg[15:0]),
    .op_shift            (opin_reg[`SQA_OPIN_SH_HI:`SQA_OPIN_SH_LO]),
    .sign_ext_mode_bit   (status_word_one[`SQA_SW1_SEXT]),
    .prod_shifted        (prod_shifted),
    .op_shifted          (op_shifted)
  );

  // Read decode shared by the bus read path
  function [31:0] rd_mux;
    input [7:0] a;
    begin
      rd_mux = 32'h0000_0000;
      case (a)
        `SQA_OFF_CMD:   rd_mux = {16'h0000, cmd_reg};
        `SQA_OFF_DADDR: rd_mux = {16'h0000, daddr_reg};
        `SQA_OFF_SW0:   rd_mux = {16'h0000, status_word_zero};
        `SQA_OFF_SW1:   rd_mux = {16'h0000, status_word_one};
        `SQA_OFF_ACC:   rd_mux = acc_reg;
        `SQA_OFF_PROD:  rd_mux = prod_reg;
        `SQA_OFF_MCAND: rd_mux = {16'h0000, multiplicand_register};
        `SQA_OFF_STAT:  rd_mux = {31'h0000_0000, ~state_reg[0]};
        `SQA_OFF_OPIN:  rd_mux = {12'h000, opin_reg};
        `SQA_OFF_OPOUT: rd_mux = op_shifted;
        default: begin
          if (a >= `SQA_OFF_AR_BASE && a <= `SQA_OFF_AR_LAST &&
              a[1:0] == 2'b00)
            rd_mux = {16'h0000, ar_reg[a[4:2]]};
        end
      endcase
    end
  endfunction

  // Read data registered in the address phase, valid in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata      <= `SQA_RST_32;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= `SQA_RST_8;
    end else begin
      wr_pend_reg <= addr_ok & hwrite;
      if (addr_ok)
        wr_addr_reg <= haddr[7:0];
      if (addr_ok & ~hwrite)
        hrdata <= rd_mux(haddr[7:0]);
    end
  end

  // Bus writes and the instruction sequencer share the register file;
  // sequencer updates win since software should not touch a busy core
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg             <= S_IDLE;
      cmd_reg               <= `SQA_RST_16;
      daddr_reg             <= `SQA_RST_16;
      status_word_zero      <= `SQA_RST_16;
      status_word_one       <= `SQA_RST_16;
      acc_reg               <= `SQA_RST_32;
      prod_reg              <= `SQA_RST_32;
      multiplicand_register <= `SQA_RST_16;
      opin_reg              <= `SQA_RST_20;
      go_reg                <= 1'b0;
      dmem_req              <= 1'b0;
      dmem_we               <= 1'b0;
      dmem_addr             <= `SQA_RST_16;
      dmem_wdata            <= `SQA_RST_16;
      for (i = 0; i < 8; i = i + 1)
        ar_reg[i] <= `SQA_RST_16;
    end else begin
      go_reg   <= 1'b0;
      dmem_req <= 1'b0;
      dmem_we  <= 1'b0;
      if (wr_pend_reg) begin
        case (wr_addr_reg)
          `SQA_OFF_CMD: begin
            if (state_reg[0]) begin  // Commands while busy are dropped
              cmd_reg <= hwdata[15:0];
              go_reg  <= 1'b1;
            end
          end
          `SQA_OFF_DADDR: daddr_reg        <= hwdata[15:0];
          `SQA_OFF_SW0:   status_word_zero <= hwdata[15:0];
          `SQA_OFF_SW1:   status_word_one  <= hwdata[15:0];
          `SQA_OFF_ACC:   acc_reg          <= hwdata;
          `SQA_OFF_PROD:  prod_reg         <= hwdata;
          `SQA_OFF_OPIN:  opin_reg         <= hwdata[19:0];
          default: begin
            if (wr_addr_reg >= `SQA_OFF_AR_BASE &&
                wr_addr_reg <= `SQA_OFF_AR_LAST &&
                wr_addr_reg[1:0] == 2'b00)
              ar_reg[wr_addr_reg[4:2]] <= hwdata[15:0];
          end
        endcase
      end
      case (state_reg)
        S_IDLE: begin
          if (go_reg) begin
            case (cmd_op)
              `SQA_OP_SQ_ADD: begin
                acc_reg   <= acc_reg + prod_shifted;  // RULE_01
                dmem_req  <= 1'b1;
                dmem_addr <= eff_addr;
                state_reg <= S_READ;
              end
              `SQA_OP_SQ_SUB: begin
                acc_reg   <= acc_reg - prod_shifted;  // RULE_02
                dmem_req  <= 1'b1;
                dmem_addr <= eff_addr;
                state_reg <= S_READ;
              end
              `SQA_OP_STORE0: begin
                dmem_wdata <= status_word_zero;       // RULE_04
                dmem_req   <= 1'b1;
                dmem_we    <= 1'b1;
                dmem_addr  <= eff_addr;
                state_reg  <= S_WRITE;
              end
              `SQA_OP_STORE_N: begin
                // Only two status words exist; other indices store zero
                case (cmd_reg[`SQA_CMD_N_HI:`SQA_CMD_N_LO])
                  3'h0:    dmem_wdata <= status_word_zero; // RULE_05
                  3'h1:    dmem_wdata <= status_word_one;  // RULE_05
                  default: dmem_wdata <= `SQA_RST_16;
                endcase
                dmem_req  <= 1'b1;
                dmem_we   <= 1'b1;
                dmem_addr <= eff_addr;
                state_reg <= S_WRITE;
              end
              `SQA_OP_STORE1: begin
                dmem_wdata <= status_word_one;        // RULE_06
                dmem_req   <= 1'b1;
                dmem_we    <= 1'b1;
                dmem_addr  <= eff_addr;
                state_reg  <= S_WRITE;
              end
              `SQA_OP_SET_SEXT:
                status_word_one[`SQA_SW1_SEXT] <= 1'b1;   // RULE_07
              `SQA_OP_SET_TEST:
                status_word_one[`SQA_SW1_TEST] <= 1'b1;   // RULE_09
              `SQA_OP_SET_TXMODE: begin
                if (HAS_TX_MODE != 0)
                  status_word_one[`SQA_SW1_TXMODE] <= 1'b1; // RULE_10
              end
              default: state_reg <= S_IDLE;
            endcase
          end
        end
        S_READ: state_reg <= S_EXEC;  // Memory answers one cycle later
        S_EXEC: begin
          multiplicand_register <= sq_op;                 // RULE_01 RULE_02
          prod_reg <= sq_wide * sq_wide;                  // RULE_01 RULE_02
          state_reg <= S_IDLE;
        end
        S_WRITE: state_reg <= S_IDLE;
        default: state_reg <= S_IDLE;
      endcase
      // Pointer reload once the memory access is over
      if ((state_reg[2] | state_reg[3]) && cmd_reg[`SQA_CMD_IND] &&
          cmd_reg[`SQA_CMD_NXT_EN])
        status_word_zero[`SQA_SW0_PTR_HI:`SQA_SW0_PTR_LO] <=
          cmd_reg[`SQA_CMD_NXT_HI:`SQA_CMD_NXT_LO];      // RULE_11
    end
  end
endmodule

// [tb/sqa_core_assertions.sv]
`timescale 1ns/1ps
module sqa_core_chk (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        dmem_req,
  input wire        dmem_we,
  input wire [15:0] dmem_addr,
  input wire [15:0] dmem_wdata
);
  reg cmd_ph;
  wire [3:0] op = hwdata[3:0];
  // Flags the data phase of a command write
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cmd_ph <= 1'b0;
    else cmd_ph <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == 0;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_sq_reads: assert property (cmd_ph && op inside {1, 2}
    |-> ##2 dmem_req && !dmem_we) else $error("square op missed read");
  chk_sq_quiet: assert property (cmd_ph && op inside {1, 2}
    |-> ##3 !dmem_req [*2]) else $error("square op extra access");
  chk_store_wr: assert property (cmd_ph && op inside {3, 4, 5}
    |-> ##2 dmem_req && dmem_we) else $error("store missed write");
  chk_set_nomem: assert property (cmd_ph && op inside {6, 7, 8}
    |-> ##1 !dmem_req [*3]) else $error("set op touched memory");
  chk_req_pulse: assert property (dmem_req |=> !dmem_req)
    else $error("access strobe too long");
  chk_we_req: assert property (dmem_we |-> dmem_req)
    else $error("write strobe alone");
  chk_addr_hold: assert property (!dmem_req |-> $stable(dmem_addr))
    else $error("address moved while idle");
  chk_wdata_hold: assert property (
    !dmem_req |-> $stable(dmem_wdata))
    else $error("store data moved while idle");
  cover property (cmd_ph && op == 4'h2);
  cover property (dmem_req && dmem_we);
  cover property (cmd_ph && op == 4'h8);
endmodule
bind sqa_core sqa_core_chk u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .dmem_req(dmem_req),
  .dmem_we(dmem_we), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata));

// [tb/sqa_dmem_model.sv]
`timescale 1ns/1ps
module sqa_dmem_model (
  input  wire        hclk,
  input  wire        dmem_req,
  input  wire        dmem_we,
  input  wire [15:0] dmem_addr,
  input  wire [15:0] dmem_wdata,
  output reg  [15:0] dmem_rdata
);
  reg [15:0] mem [0:15];
  initial dmem_rdata = 16'h5a5a;
  // Read data lives one cycle only, then flips so stale use shows up
  always @(posedge hclk) begin
    if (dmem_req && dmem_we) mem[dmem_addr[3:0]] <= dmem_wdata;
    dmem_rdata <= (dmem_req && !dmem_we) ? mem[dmem_addr[3:0]] : ~dmem_rdata;
  end
endmodule

// [tb/square_accumulate_status_ops_bench.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module square_accumulate_status_ops_bench;
  localparam [7:0] A_CMD = 8'h00, A_DAD = 8'h04, A_SW0 = 8'h08;
  localparam [7:0] A_SW1 = 8'h0c, A_ACC = 8'h10, A_PRD = 8'h14;
  localparam [7:0] A_MCD = 8'h18, A_OPI = 8'h20, A_OPO = 8'h24;
  reg        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  reg [31:0] haddr = 0, hwdata = 0, rd, p;
  reg [1:0]  htrans = 0;
  reg [2:0]  hsize = 3'b010;
  wire        hreadyout, hresp, dmem_req, dmem_we;
  wire [31:0] hrdata;
  wire [15:0] dmem_addr, dmem_wdata, dmem_rdata;
  int n_fail = 0, total_checks = 0, i;
  reg [31:0] sc [0:4] = '{32'h3, 32'h5, 32'h4, 32'h24, 32'h44};
  reg [15:0] se [0:4] = '{16'h2a5a, 16'h0001, 16'h2a5a, 16'h0001, 16'h0};
  always #2.5 hclk = ~hclk;
  sqa_core u_sqa_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .dmem_req(dmem_req), .dmem_we(dmem_we),
    .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata));
  sqa_dmem_model u_sqa_dmem_model (.hclk(hclk), .dmem_req(dmem_req),
    .dmem_we(dmem_we), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
    .dmem_rdata(dmem_rdata));
  // One single transfer; a leading edge keeps an idle between transfers
  task bus(input w, input [7:0] a, input [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task wr(input [7:0] a, input [31:0] d); bus(1'b1, a, d); endtask
  task ck(input [7:0] a, input [31:0] e); bus(1'b0, a, 0); `CHK(rd, e) endtask
  // Busy may rise a cycle late, so let the command start before polling
  task run(input [31:0] c);
    wr(A_CMD, c);
    repeat (4) @(posedge hclk);
    do bus(1'b0, 8'h1c, 0); while (rd[0] !== 1'b0);
  endtask
  function [31:0] shf(input [1:0] m, input [31:0] v);
    case (m)
      2'd0: shf = v;
      2'd1: shf = v << 1;
      2'd2: shf = v << 4;
      default: shf = $signed(v) >>> 6;
    endcase
  endfunction
  task summarize;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Whole run needs well under a tenth of this
  initial begin
    #100000;
    n_fail++;
    summarize;
  end
  initial begin
    u_sqa_dmem_model.mem[2] = 16'hfffd;
    u_sqa_dmem_model.mem[5] = 16'h0100;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    ck(A_ACC, 0);
    p = 32'h8000_0100;
    for (i = 0; i < 4; i++) begin
      wr(A_SW1, i); wr(A_ACC, 32'h7); wr(A_PRD, p); wr(A_DAD, 32'h2);
      run(32'h1);
      ck(A_ACC, 32'h7 + shf(i[1:0], p));
      ck(A_PRD, 32'h9);
      ck(A_MCD, 32'h0000_fffd);
    end
    $display("square add done");
    wr(A_SW1, 1); wr(A_ACC, 32'h64); wr(A_PRD, 32'h10);
    wr(8'h4c, 32'h5); wr(A_SW0, 32'h6000);
    run(32'h0000_0d12);
    ck(A_ACC, 32'h44);
    ck(A_PRD, 32'h0001_0000);
    ck(A_SW0, 32'h0000_c000);
    $display("square sub done");
    wr(A_SW0, 32'h2a5a); wr(A_SW1, 32'h1); wr(8'h44, 32'hc);
    for (i = 0; i < 5; i++) begin
      wr(A_DAD, 7 + i);
      run(sc[i]);
      `CHK(u_sqa_dmem_model.mem[7 + i], se[i])
    end
    run(32'h34);
    `CHK(u_sqa_dmem_model.mem[12], 16'h0001)
    $display("status store done");
    wr(A_SW1, 0);
    run(6);
    ck(A_SW1, 32'h400);
    run(7);
    ck(A_SW1, 32'hc00);
    run(8);
    ck(A_SW1, 32'hc04);
    run(9);
    ck(A_SW1, 32'hc04);
    wr(A_OPI, 32'h0004_8001);
    ck(A_OPO, 32'hfff8_0010);
    wr(A_SW1, 0);
    ck(A_OPO, 32'h0008_0010);
    ck(8'h30, 0);
    $display("set ops done");
    summarize;
  end
endmodule
